// ---- rtl/cpu_tick_gen.v ----
// Purpose: Produces the CPU clock tick from the master clock.
// Assumes: Master clock is mclk itself.
// Notes: Ratio changes only at a tick boundary.
`include "power_saving_mode_control_regs.vh"

module cpu_tick_gen
(
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Slow mode selection
  input wire slow,
  input wire [1:0] div_sel,
  // Tick out
  output reg tick
);

  reg [3:0] cnt; // Master clock cycles in period
  reg slow_l; // Slow select in force
  reg [1:0] sel_l; // Divider select in force
  wire last; // Final cycle of current period

  // Last count of a period for each divider
  function [3:0] div_last;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: div_last = 4'h1;
        2'h1: div_last = 4'h3;
        2'h2: div_last = 4'h7;
        default: div_last = 4'hF;
      endcase
    end
  endfunction

  assign last = slow_l ? (cnt == div_last(sel_l)) : 1'b1;

  // Period counter; new ratio taken only at period end
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt <= 4'h0;
      slow_l <= 1'b0;
      sel_l <= 2'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= last;
      if (last)
      begin
        // Whole periods only, so no short pulse
        cnt <= 4'h0;
        slow_l <= slow;
        sel_l <= div_sel;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end

endmodule // cpu_tick_gen

// ---- rtl/power_saving_mode_control.v ----
// Purpose: Power mode sequencer: run, slow, wait, active-halt, halt.
// Assumes: Core requests and interrupts come from mclk logic.
// Notes: Clocks leave as registered enables, never gated clocks.
`include "power_saving_mode_control_regs.vh"

module power_saving_mode_control
#(
  parameter [12:0] SHORT_COUNT = `STAB_SHORT,
  parameter [12:0] LONG_COUNT = `STAB_LONG
)
(
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core instruction events
  input wire wait_for_interrupt_instr,
  input wire halt_instr,
  // Interrupt sources
  input wire irq_pending,
  input wire timebase_irq,
  input wire [4:0] halt_wake_irq,
  // Watchdog
  input wire watchdog_active,
  // Clock enables
  output reg cpu_clk_en,
  output reg periph_clk_en,
  output reg timebase_clk_en,
  output reg osc_enable,
  // Core side effects
  output reg ipl_force,
  output wire [1:0] ipl_value,
  output reg service_start,
  output reg watchdog_reset_req
);

  ////////////////////////////////////////////////////////////////////
  // Mode states
  localparam [4:0] ST_RUN = 5'h01; // Run or slow
  localparam [4:0] ST_WAIT = 5'h02; // Wait or slow-wait
  localparam [4:0] ST_AHALT = 5'h04; // Active-halt
  localparam [4:0] ST_HALT = 5'h08; // Full halt
  localparam [4:0] ST_STAB = 5'h10; // Oscillator settling

  reg [4:0] state; // Current mode
  reg [4:0] next_state; // Mode after this cycle
  reg [3:0] clock_ctrl; // Clock controller status register
  reg [1:0] config_bits; // Delay and watchdog options
  reg tail_active; // Delay after active-halt wake
  reg svc_after_stab; // Interrupt waits behind delay
  reg stab_start; // Load delay counter
  reg wake_now; // Start service this cycle
  reg enter_low; // Entry into a low power state
  reg wdg_now; // Halt watchdog reset this cycle
  wire tick; // CPU clock tick
  wire stab_busy; // Delay counting
  wire stab_done; // Delay finished
  wire slow_mode_select; // Slow mode enable
  wire [1:0] slow_clock_divider_select; // Slow divider select
  wire timebase_irq_enable; // Time-base interrupt enable
  wire long_delay; // 4096 cycle delay option
  wire watchdog_halt_option; // Halt makes watchdog reset
  wire halt_wake; // Any source allowed to end halt

  assign slow_mode_select = clock_ctrl[`BIT_SLOW_MODE_SELECT];
  assign slow_clock_divider_select =
    clock_ctrl[`BIT_DIV_SEL_HI:`BIT_DIV_SEL_LO];
  assign timebase_irq_enable = clock_ctrl[`BIT_TIMEBASE_IRQ_ENABLE];
  assign long_delay = config_bits[`BIT_LONG_DELAY];
  assign watchdog_halt_option = config_bits[`BIT_WATCHDOG_HALT_OPTION];
  // Top-level, ports, bus controller, SPI slave, reload timer
  assign halt_wake = |halt_wake_irq;
  assign ipl_value = `IPL_ALL_ENABLED;

  ////////////////////////////////////////////////////////////////////
  // Sub-blocks

  // CPU tick, glitch-free ratio change
  cpu_tick_gen u_tick
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .slow(slow_mode_select),
    .div_sel(slow_clock_divider_select),
    .tick(tick)
  );

  // Oscillator stabilisation delay
  stab_counter
  #(
    .SHORT_COUNT(SHORT_COUNT),
    .LONG_COUNT(LONG_COUNT)
  )
  u_stab
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(stab_start),
    .long_delay(long_delay),
    .busy(stab_busy),
    .done(stab_done)
  );

  ////////////////////////////////////////////////////////////////////
  // Mode sequencing

  // Next mode and side effects
  always @*
  begin
    next_state = state;
    stab_start = 1'b0;
    wake_now = 1'b0;
    enter_low = 1'b0;
    wdg_now = 1'b0;
    case (state)
      ST_RUN:
      begin
        if (tail_active && !timebase_irq_enable)
          // Enable dropped early: clocks stop for the rest
          next_state = ST_STAB;
        else if (halt_instr)
        begin
          enter_low = 1'b1;
          if (timebase_irq_enable)
            next_state = ST_AHALT;
          else
          begin
            next_state = ST_HALT;
            wdg_now = watchdog_active && watchdog_halt_option;
          end
        end
        else if (wait_for_interrupt_instr)
        begin
          // Slow setting untouched, so slow-wait
          next_state = ST_WAIT;
          enter_low = 1'b1;
        end
      end
      ST_WAIT:
      begin
        // Any interrupt ends wait
        if (irq_pending)
        begin
          next_state = ST_RUN;
          wake_now = 1'b1;
        end
      end
      ST_AHALT:
      begin
        // Only the time-base wakes, with no delay
        if (timebase_irq)
        begin
          next_state = ST_RUN;
          wake_now = 1'b1;
          stab_start = 1'b1;
        end
      end
      ST_HALT:
      begin
        // Oscillator back on, then settle
        if (halt_wake)
        begin
          next_state = ST_STAB;
          stab_start = 1'b1;
        end
      end
      ST_STAB:
      begin
        if (stab_done || !stab_busy)
        begin
          next_state = ST_RUN;
          wake_now = svc_after_stab;
        end
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  // Mode register and flags
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Reset exit always passes the settling delay
      state <= ST_STAB;
      tail_active <= 1'b0;
      svc_after_stab <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_HALT && halt_wake)
        svc_after_stab <= 1'b1;
      else if (state == ST_STAB && next_state == ST_RUN)
        svc_after_stab <= 1'b0;
      if (state == ST_AHALT && timebase_irq)
        tail_active <= 1'b1;
      else if (stab_done || !stab_busy)
        tail_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock enables and core strobes

  // Enables registered from mode and tick
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      timebase_clk_en <= 1'b0;
      osc_enable <= 1'b1;
      ipl_force <= 1'b0;
      service_start <= 1'b0;
      watchdog_reset_req <= 1'b0;
    end
    else
    begin
      // Only whole ticks pass, so no short pulse
      cpu_clk_en <= tick && (next_state == ST_RUN);
      periph_clk_en <= tick &&
        (next_state == ST_RUN || next_state == ST_WAIT);
      timebase_clk_en <= tick && (next_state == ST_RUN ||
        next_state == ST_WAIT || next_state == ST_AHALT);
      osc_enable <= (next_state != ST_HALT);
      ipl_force <= enter_low;
      // Core stacks condition codes and branches on this strobe
      service_start <= wake_now;
      watchdog_reset_req <= wdg_now;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg aw_held; // Write address taken
  reg w_held; // Write data taken
  reg [3:0] aw_addr; // Held write address
  reg [31:0] w_data; // Held write data
  reg [3:0] w_strb; // Held byte strobes
  reg ar_busy; // Read answer outstanding
  wire do_write; // Both halves present

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !ar_busy;
  assign do_write = aw_held && w_held;

  // Word-aligned decode of a known offset
  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `OFS_CLOCK_CTRL) || (addr == `OFS_CONFIG) ||
        (addr == `OFS_STATUS);
    end
  endfunction

  // Write channels, either order, then response
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      clock_ctrl <= `RST_CLOCK_CTRL;
      config_bits <= `RST_CONFIG;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        // Low byte holds every writable bit
        if (w_strb[0] && aw_addr == `OFS_CLOCK_CTRL)
          clock_ctrl <= w_data[3:0];
        if (w_strb[0] && aw_addr == `OFS_CONFIG)
          config_bits <= w_data[1:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel, answer one cycle after address
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ar_busy <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      ar_busy <= 1'b1;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_CLOCK_CTRL: s_axi_rdata <= {28'h0000000, clock_ctrl};
        `OFS_CONFIG: s_axi_rdata <= {30'h0, config_bits};
        `OFS_STATUS: s_axi_rdata <= {23'h0, stab_busy,
          tail_active, osc_enable, slow_mode_select, state};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      ar_busy <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // power_saving_mode_control

// ---- rtl/power_saving_mode_control_regs.vh ----
// Purpose: Constants of the power saving mode sequencer.
// Assumes: Included by every design file of the sequencer.
// Notes: Offsets are AXI4-Lite byte addresses, one word each.
//
// Behaviour
// - Reset ends in run mode on master clock
// - Slow mode divides master clock by 2..16
// - Wait while slow keeps the slow clock
// - Wait stops CPU clock, peripherals keep running
// - Wait entry forces priority bits to 10
// - Wait lasts until interrupt or reset
// - Core stacks condition codes, then services wake
// - Halt picks active-halt when time-base enabled
// - Active-halt exits on time-base, no delay
// - Active-halt delay applies only if time-base enable drops
// - Halt entry forces 10; pending interrupt alone does not wake
// - Active-halt clocks only oscillator and time-base
// - Active-halt with time-base raises no watchdog reset
// - Halt exit restarts oscillator, waits 256/4096
// - Full halt stops oscillator and all processing
// - Watchdog halt option selects halt watchdog reset
// - Only listed sources wake from full halt
`ifndef POWER_SAVING_MODE_CONTROL_REGS_VH
`define POWER_SAVING_MODE_CONTROL_REGS_VH

// Register offsets
`define OFS_CLOCK_CTRL 4'h0
`define OFS_CONFIG 4'h4
`define OFS_STATUS 4'h8

// Clock controller status register fields
`define BIT_SLOW_MODE_SELECT 0
`define BIT_DIV_SEL_LO 1
`define BIT_DIV_SEL_HI 2
`define BIT_TIMEBASE_IRQ_ENABLE 3

// Configuration register fields
`define BIT_LONG_DELAY 0
`define BIT_WATCHDOG_HALT_OPTION 1

// Reset values
`define RST_CLOCK_CTRL 4'h0
`define RST_CONFIG 2'h0

// Stabilisation counts in master clock cycles
`define STAB_SHORT 13'h0100
`define STAB_LONG 13'h1000

// Priority value forced on low power entry
`define IPL_ALL_ENABLED 2'h2

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- rtl/stab_counter.v ----
// Purpose: Oscillator stabilisation delay counter.
// Assumes: Counts one per master clock cycle.
// Notes: Reset starts a short delay, as the option resets to short.
`include "power_saving_mode_control_regs.vh"

module stab_counter
#(
  parameter [12:0] SHORT_COUNT = `STAB_SHORT,
  parameter [12:0] LONG_COUNT = `STAB_LONG
)
(
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Control
  input wire start,
  input wire long_delay,
  // Status
  output wire busy,
  output reg done
);

  reg [12:0] left; // Cycles still to wait

  assign busy = (left != 13'h0000);

  // Load on start, count down, pulse at zero
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      left <= SHORT_COUNT;
      done <= 1'b0;
    end
    else if (start)
    begin
      left <= long_delay ? LONG_COUNT : SHORT_COUNT;
      done <= 1'b0;
    end
    else
    begin
      done <= (left == 13'h0001);
      if (busy)
        left <= left - 13'h0001;
    end
  end

endmodule // stab_counter

// ---- verif/core_model.sv ----
// Purpose: Core model issuing wait and halt instructions.
// Assumes: Instructions execute on a CPU clock tick.
// Notes: Never halts unless the bench commands it.
module core_model (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Command and CPU tick
  input wire [1:0] cmd,
  input wire cpu_clk_en,
  // Instruction events
  output logic wait_for_interrupt_instr,
  output logic halt_instr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] req;  // Pending instruction
  // One-cycle instruction pulse on a CPU tick
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req <= 2'h0;
      wait_for_interrupt_instr <= 1'b0;
      halt_instr <= 1'b0;
    end
    else
    begin
      wait_for_interrupt_instr <= 1'b0;
      halt_instr <= 1'b0;
      if (cmd != 2'h0)
        req <= cmd;
      else if (req != 2'h0 && cpu_clk_en)
      begin
        wait_for_interrupt_instr <= req == 2'h1;
        halt_instr <= req == 2'h2;
        req <= 2'h0;
      end
    end
  end
endmodule // core_model

// ---- verif/power_saving_mode_control_bench.sv ----
// Purpose: Self-checking bench of the power mode sequencer.
// Assumes: Stabilisation counts shortened to 4 and 8.
// Notes: Core model executes wait and halt on command.
module power_saving_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 4;
  localparam int LC = 8;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic irq_pending = 1'b0, timebase_irq = 1'b0, watchdog_active = 1'b0;
  logic [4:0] halt_wake_irq = 5'h0;
  logic [1:0] cmd = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, wait_for_interrupt_instr, halt_instr;
  wire [1:0] s_axi_bresp, s_axi_rresp, ipl_value;
  wire [31:0] s_axi_rdata;
  wire cpu_clk_en, periph_clk_en, timebase_clk_en, osc_enable;
  wire ipl_force, service_start, watchdog_reset_req;
  wire [2:0] ev = {service_start, ipl_force, cpu_clk_en};
  int mismatches = 0, check_count = 0, wd = 0;
  int n, t, a, p, q, o, s, w0;
  logic [1:0] resp;
  logic [31:0] rd;
  always #25 mclk = ~mclk;
  // Counts watchdog requests
  always @(posedge mclk) wd <= wd + (watchdog_reset_req === 1'b1);
  power_saving_mode_control #(.SHORT_COUNT(13'h0004),
    .LONG_COUNT(13'h0008)) dut_u (.mclk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wait_for_interrupt_instr, .halt_instr, .irq_pending, .timebase_irq,
    .halt_wake_irq, .watchdog_active, .cpu_clk_en, .periph_clk_en,
    .timebase_clk_en, .osc_enable, .ipl_force, .ipl_value,
    .service_start, .watchdog_reset_req);
  core_model core_u (.mclk, .sys_rst, .cmd, .cpu_clk_en,
    .wait_for_interrupt_instr, .halt_instr);
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // Bus write, both halves offered together
  task axw(input logic [3:0] ad, input logic [31:0] d);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) mismatches++;
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  // Bus read
  task axr(input logic [3:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) mismatches++;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  // Edges until an event is sampled high
  task await(input int i);
    t = 0;
    do
    begin
      @(posedge mclk);
      t++;
    end
    while (ev[i] !== 1'b1 && t < 100);
  endtask
  // Core executes an instruction; priority force expected
  task issue(input logic [1:0] k);
    cmd <= k;
    @(posedge mclk);
    cmd <= 2'h0;
    await(1);
    chk(t < 100, 1);
  endtask
  // Tally the outputs over some cycles
  task watch(input int k);
    {a, p, q, o, s} = '0;
    repeat (k)
    begin
      @(posedge mclk);
      a += cpu_clk_en;
      p += periph_clk_en;
      q += timebase_clk_en;
      o += osc_enable;
      s += service_start;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    await(0);
    chk(t >= SC && t < SC + 8, 1);
    axr(4'h8);
    chk({rd[6], rd[4:0]}, 6'h21);
    axr(4'h0);
    chk(rd, 32'h0);
    axr(4'h4);
    chk(rd, 32'h0);
    axr(4'hC);
    chk({resp, rd[7:0]}, 10'h200);
    axw(4'hC, 32'h1);
    chk(resp, 2'h2);
  endtask
  task t_slow;
    for (int k = 0; k < 4; k++)
    begin
      axw(4'h0, k * 2 + 1);
      repeat (3) await(0);
      chk(t, 2 << k);
    end
  endtask
  task t_wait;
    axw(4'h0, 32'h1);
    issue(2'h1);
    watch(8);
    chk(a + s, 0);
    chk(p, 4);
    irq_pending <= 1'b1;
    await(2);
    chk(t <= 3, 1);
    irq_pending <= 1'b0;
    axw(4'h0, 32'h0);
  endtask
  task t_ahalt;
    axw(4'h4, 32'h2);
    axw(4'h0, 32'h8);
    watchdog_active <= 1'b1;
    w0 = wd;
    issue(2'h2);
    irq_pending <= 1'b1;
    watch(8);
    chk(o, 8);
    chk(a + p + s, 0);
    chk(q > 0, 1);
    chk(wd - w0, 0);
    timebase_irq <= 1'b1;
    await(2);
    chk(t <= 3, 1);
    {irq_pending, timebase_irq, watchdog_active} <= 3'h0;
    // Window flag and settle counter both up just after wake
    axr(4'h8);
    chk(rd[8:7], 2'h3);
    repeat (SC + 4) @(posedge mclk);
  endtask
  task t_halt;
    axw(4'h4, 32'h3);
    axw(4'h0, 32'h0);
    for (int b = 0; b < 5; b++)
    begin
      w0 = wd;
      watchdog_active <= b == 0;
      issue(2'h2);
      {irq_pending, timebase_irq} <= 2'h3;
      watch(8);
      chk(o + a + p + q + s, 0);
      halt_wake_irq <= 5'h1 << b;
      await(2);
      chk(t >= LC && t <= LC + 4, 1);
      chk(wd - w0, b == 0);
      {irq_pending, timebase_irq, watchdog_active} <= 3'h0;
      halt_wake_irq <= 5'h0;
      repeat (4) @(posedge mclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_slow;
    t_wait;
    t_ahalt;
    t_halt;
    end_of_test;
  end
  // Cuts a hang short
  initial
  begin
    #(50 * 5000);
    mismatches++;
    end_of_test;
  end
endmodule // power_saving_mode_control_bench

// ---- verif/power_saving_mode_control_properties.sv ----
// Purpose: Port-level checks of the power mode sequencer.
// Assumes: One clock domain, reset active high.
// Notes: Bound to the top module at the foot of this file.
module power_saving_mode_control_properties (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Core and watchdog inputs
  input wire halt_instr,
  input wire watchdog_active,
  // Clock enables
  input wire cpu_clk_en,
  input wire periph_clk_en,
  input wire timebase_clk_en,
  input wire osc_enable,
  // Core side effects
  input wire ipl_force,
  input wire [1:0] ipl_value,
  input wire service_start,
  input wire watchdog_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Full halt entry: oscillator stops with priority forced
  sequence halt_entry;
    $fell(osc_enable) ##0 ipl_force;
  endsequence
  // Oscillator restart: nothing serviced for three cycles
  sequence settle_wait;
    !service_start [*3];
  endsequence
  ipl_value_a: assert property (
    ipl_force |-> ipl_value == 2'h2) else $error("priority value wrong");
  halt_entry_a: assert property (
    $fell(osc_enable) |-> halt_entry and !cpu_clk_en)
    else $error("halt entry wrong");
  osc_off_a: assert property (
    !osc_enable |-> !cpu_clk_en && !periph_clk_en && !timebase_clk_en)
    else $error("clock enable with oscillator off");
  settle_hold_a: assert property (
    $rose(osc_enable) |-> settle_wait) else $error("service too early");
  wdog_cause_a: assert property (
    watchdog_reset_req |-> $past(halt_instr) && $past(watchdog_active))
    else $error("watchdog request without cause");
  no_wdog_ahalt_a: assert property (
    ipl_force && osc_enable |-> !watchdog_reset_req)
    else $error("watchdog request in low power");
  cpu_stop_a: assert property (
    ipl_force && osc_enable |-> !cpu_clk_en) else $error("cpu runs");
  ipl_pulse_a: assert property (
    ipl_force |=> !ipl_force) else $error("priority force too long");
  run_tick_a: assert property (
    cpu_clk_en |-> periph_clk_en && timebase_clk_en)
    else $error("cpu tick without peripheral tick");
  svc_run_a: assert property (
    service_start |-> osc_enable && !ipl_force)
    else $error("service while stopped");
endmodule // power_saving_mode_control_properties

bind power_saving_mode_control power_saving_mode_control_properties
  props_u (.mclk, .sys_rst, .halt_instr, .watchdog_active, .cpu_clk_en,
  .periph_clk_en, .timebase_clk_en, .osc_enable, .ipl_force, .ipl_value,
  .service_start, .watchdog_reset_req);
